/* bench/cond_source_model.sv */
// far-side model: console switches, data path and decoder levels
`timescale 1ns/1ps
module cond_source_model
  import useq_pkg::*;
(
  input wire logic clk_sys, // machine clock
  input wire logic rstn, // async reset, active low
  input wire logic [20+TRAP_W:0] cmd, // levels asked for by the bench
  output logic halt_switch_active, // high = halt
  output logic console_request, // console bus request
  output logic memory_mgmt_fault, // fault level
  output logic service_request, // service pending
  output logic fetch_overlap, // overlap possible
  output logic [15:0] instr_reg, // decoded instruction
  output logic [TRAP_W-1:0] trap_request // trap requests
);
  // levels move only just after a rising edge, like the real data path
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {halt_switch_active, console_request, memory_mgmt_fault, service_request, fetch_overlap, instr_reg,
        trap_request} <= '0;
    end else begin
      {halt_switch_active, console_request, memory_mgmt_fault, service_request, fetch_overlap, instr_reg,
        trap_request} <= cmd;
    end
  end
endmodule

/* bench/microprogram_branch_sequencer_tb_top.sv */
// self-checking bench for the microprogram branch sequencer
`timescale 1ns/1ps
module microprogram_branch_sequencer_tb_top;
  import useq_pkg::*;
  logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, init_pulse, restart_delay_start, err;
  logic halt_switch_active, console_request, memory_mgmt_fault, service_request, fetch_overlap;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [WORD_W-1:0] microword;
  logic [7:0] ptr, prev, p, q, nx, md;
  logic [2:0] display_select;
  logic [TRAP_W-1:0] trap_pending, trap_request, tr;
  logic [15:0] instr_reg;
  logic [20+TRAP_W:0] cmd;
  logic [4:0] c0;
  logic [4:0] codes [10];
  logic [31:0] store [256];
  int num_errors, compares, seed, n;

  microprogram_branch_sequencer i_microprogram_branch_sequencer (.clk_sys, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .halt_switch_active, .console_request, .memory_mgmt_fault,
    .service_request, .fetch_overlap, .instr_reg, .trap_request, .next_microaddress_pointer(ptr),
    .previous_microaddress(prev), .microword, .display_select, .init_pulse, .restart_delay_start,
    .trap_pending);
  cond_source_model i_cond_source_model (.clk_sys, .rstn, .cmd, .halt_switch_active, .console_request,
    .memory_mgmt_fault, .service_request, .fetch_overlap, .instr_reg, .trap_request);

  // machine clock, 100 ns
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected address modifier of a branch code
  function automatic logic [7:0] modf(input logic [4:0] c);
    case (c)
      BR_CONSOLE_ONE: return console_request ? MOD_ONE : MOD_NONE;
      BR_CONSOLE_TWO, BR_HALT: return halt_switch_active ? MOD_ONE : MOD_NONE;
      BR_MEM_FAULT: return memory_mgmt_fault ? MOD_ONE : MOD_NONE;
      BR_SVCFETCH: return service_request ? MOD_SERVICE : (fetch_overlap ? MOD_OVERLAP : MOD_NONE);
      BR_WRSEL: return instr_reg[5:3] != 3'h0 ? WR_NONE : (instr_reg[15] ? WR_BYTE : WR_WORD);
      BR_DISPATCH: return {3'h0, (instr_reg[15:11] > DISPATCH_LAST) ? DISPATCH_LAST : instr_reg[15:11]};
      default: return MOD_NONE;
    endcase
  endfunction

  // watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    complete_run();
  end

  task automatic complete_run();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, cmd} = '0;
    seed = 68908;
    codes = '{BR_NONE, BR_CONSOLE_ONE, BR_CONSOLE_TWO, BR_TRAP_CLEAR, BR_HALT, BR_MEM_FAULT, BR_SVCFETCH, BR_WRSEL,
      BR_DISPATCH, 5'h05};
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    #1 chk("ptr_rst", 8'h1A, ptr);
    for (int i = 0; i < 256; i++) begin
      store[i] = $random(seed);
      store[i][12:8] = codes[$unsigned($random(seed)) % 10];
    end
    store[26][15:0] = {3'h1, BR_NONE, 8'h40};
    apb(1'b1, OFS_ROM_ADDR, 32'h0);
    for (int i = 0; i < 256; i++) apb(1'b1, OFS_ROM_DATA, store[i]);
    apb(1'b1, OFS_CTRL, 32'h0);
    chk("idle_word", store[26], microword);
    $display("store loaded");
    for (int r = 0; r < 12; r++) begin
      @(posedge clk_sys);
      cmd <= {21'($random(seed)), {TRAP_W{1'b1}}};
      @(posedge clk_sys);
      cmd[TRAP_W-1:0] <= '0;
      repeat (6) @(posedge clk_sys);
      apb(1'b1, OFS_CTRL, 32'h1);
      #1 n = 0;
      while (ptr !== 8'h40 && n < 10) begin
        @(posedge clk_sys);
        #1 n++;
      end
      {p, q, md, tr, c0} = {8'h40, 8'h1A, 8'h0, {TRAP_W{1'b1}}, BR_NONE};
      repeat (40) begin
        chk("pointer", p, ptr);
        chk("previous", q, prev);
        chk("microword", store[p], microword);
        chk("display", store[p][15:13], display_select);
        chk("init", c0 == BR_CONSOLE_TWO, init_pulse);
        chk("restart", c0 == BR_CONSOLE_TWO, restart_delay_start);
        chk("traps", tr, trap_pending);
        // delayed branch: modifier of this word lands on the word after next
        nx = store[p][7:0] | md;
        md = modf(store[p][12:8]);
        if (store[p][12:8] == BR_TRAP_CLEAR) tr = tr & (tr - 4'h1);
        {c0, q, p} = {store[p][12:8], p, nx};
        @(posedge clk_sys);
        #1;
      end
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("status_ptr", 8'h1A, rd[7:0]);
      nx = 8'($random(seed));
      apb(1'b1, OFS_ROM_ADDR, {24'h0, nx});
      apb(1'b0, OFS_ROM_DATA, 32'h0);
      chk("rom_read", store[nx], rd);
      apb(1'b0, 12'h010 + 12'(r * 4), 32'h0);
      chk("unmapped_err", 1'b1, err);
      chk("unmapped_data", 32'h0, rd);
      $display("round %0d done", r);
    end
    complete_run();
  end
endmodule

/* hdl/microprogram_branch_sequencer.sv */
// microprogram sequencer with delayed branch tests and apb access to control store
//
// Operation
// - each state is one control-store word; start sequence begins at octal 032.
// - normally the next address comes from the current word's address field.
// - a branch test changes the word two states later, not the next one.
// - a true narrow condition ORs a one into the low address bit.
// - code 10 tests halt switch: halt goes to service, enable to fetch.
// - code 37 dispatches on instruction register to one of 25 destinations.
// - alternative conditions resolve with fixed left-to-right priority.
// - an immediate branch needs a filler word after the testing word.
// - console request test two branches on halt and starts init and restart delay.
// - register-deposit code clears pending trap flags one by one, no branching.
// - test after trap entry branches on memory management fault.
// - three-way write branch picks none, byte or word from instruction decode.
// - each word selects the register shown on the console data display.
// - code 00 means no branch.
// - pointer selects one of 256 words; store output buffered every cycle.
`timescale 1ns/1ps
module microprogram_branch_sequencer
  import useq_pkg::*;
(
  input wire logic clk_sys, // 10 MHz machine clock
  input wire logic rstn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic halt_switch_active, // console halt/enable switch pin
  input wire logic console_request, // console bus request pin
  input wire logic memory_mgmt_fault, // fault from memory management
  input wire logic service_request, // pending service from data path
  input wire logic fetch_overlap, // fetch overlap possible
  input wire logic [15:0] instr_reg, // instruction register
  input wire logic [TRAP_W-1:0] trap_request, // trap request pulses
  output logic [7:0] next_microaddress_pointer, // current store address
  output logic [7:0] previous_microaddress, // address one word back
  output logic [WORD_W-1:0] microword, // buffered microword
  output logic [2:0] display_select, // console data display source
  output logic init_pulse, // system initialise
  output logic restart_delay_start, // start restart delay
  output logic [TRAP_W-1:0] trap_pending // pending trap flags
);

  logic [WORD_W-1:0] rom_mem [256];
  logic [7:0] ptr_r, ptr_nxt, prev_r, mod_r, mod_nxt, rom_addr_r;
  logic [WORD_W-1:0] uword_r;
  logic [2:0] disp_r;
  logic run_r, init_r, delay_r;
  logic halt_meta_r, halt_sync_r, creq_meta_r, creq_sync_r;
  logic [TRAP_W-1:0] trap_r, trap_clr;
  logic [4:0] code;
  logic pready_r, pslverr_r, acc_start, acc_done, mapped, rom_we;
  logic [31:0] prdata_r, rd_mux;

  // instruction dispatch index, capped at the last destination
  function automatic logic [7:0] dispatch_index(input logic [15:0] ir);
    logic [4:0] idx;
    idx = ir[15:11];
    if (idx > DISPATCH_LAST) begin
      idx = DISPATCH_LAST;
    end
    return {3'b000, idx};
  endfunction

  // register write kind from instruction decode
  function automatic logic [7:0] write_select(input logic [15:0] ir);
    if (ir[5:3] != 3'b000) begin
      return WR_NONE;
    end
    return ir[15] ? WR_BYTE : WR_WORD;
  endfunction

  assign code = uword_r[BRANCH_LSB +: 5];

  // console pins pass two flops
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      halt_meta_r <= 1'b0;
      halt_sync_r <= 1'b0;
      creq_meta_r <= 1'b0;
      creq_sync_r <= 1'b0;
    end else begin
      halt_meta_r <= halt_switch_active;
      halt_sync_r <= halt_meta_r;
      creq_meta_r <= console_request;
      creq_sync_r <= creq_meta_r;
    end
  end

  // branch condition select
  always_comb begin
    mod_nxt = MOD_NONE;
    case (code)
      BR_NONE: mod_nxt = MOD_NONE;
      BR_CONSOLE_ONE: mod_nxt = creq_sync_r ? MOD_ONE : MOD_NONE;
      BR_CONSOLE_TWO: mod_nxt = halt_sync_r ? MOD_ONE : MOD_NONE;
      BR_TRAP_CLEAR: mod_nxt = MOD_NONE;
      // halt to service, enable to fetch
      BR_HALT: mod_nxt = halt_sync_r ? MOD_ONE : MOD_NONE;
      BR_MEM_FAULT: mod_nxt = memory_mgmt_fault ? MOD_ONE : MOD_NONE;
      BR_SVCFETCH: mod_nxt = service_request ? MOD_SERVICE : (fetch_overlap ? MOD_OVERLAP : MOD_NONE);
      BR_WRSEL: mod_nxt = write_select(instr_reg);
      BR_DISPATCH: mod_nxt = dispatch_index(instr_reg);
      default: mod_nxt = MOD_NONE;
    endcase
  end

  // condition held for the following word
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mod_r <= MOD_NONE;
    end else begin
      mod_r <= run_r ? mod_nxt : MOD_NONE;
    end
  end

  // filler word required for quick branch
  assign ptr_nxt = run_r ? (uword_r[NEXT_LSB +: 8] | mod_r) : START_ADDR;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ptr_r <= START_ADDR;
      prev_r <= START_ADDR;
      uword_r <= '0;
      disp_r <= 3'b000;
    end else begin
      ptr_r <= ptr_nxt;
      prev_r <= ptr_r;
      uword_r <= rom_mem[ptr_nxt];
      disp_r <= rom_mem[ptr_nxt][DISP_LSB +: 3];
    end
  end

  // working test starts init and delay
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      init_r <= 1'b0;
      delay_r <= 1'b0;
    end else begin
      init_r <= run_r && (code == BR_CONSOLE_TWO);
      delay_r <= run_r && (code == BR_CONSOLE_TWO);
    end
  end

  // lowest pending flag cleared, new request wins
  assign trap_clr = (run_r && code == BR_TRAP_CLEAR) ? (trap_r & (~trap_r + 4'h1)) : 4'h0;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trap_r <= 4'h0;
    end else begin
      trap_r <= (trap_r & ~trap_clr) | trap_request;
    end
  end

  // apb decode, one wait state
  assign acc_start = psel && penable && !pready_r;
  assign acc_done = psel && penable && pready_r;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_ROM_ADDR) || (paddr == OFS_ROM_DATA) ||
                  (paddr == OFS_STATUS);
  assign rom_we = acc_done && pwrite && (paddr == OFS_ROM_DATA);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: rd_mux = {31'h0, run_r};
      OFS_ROM_ADDR: rd_mux = {24'h0, rom_addr_r};
      OFS_ROM_DATA: rd_mux = rom_mem[rom_addr_r];
      OFS_STATUS: rd_mux = {12'h0, trap_r, prev_r, ptr_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // apb answer flops
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= acc_start;
      pslverr_r <= acc_start && !mapped;
      prdata_r <= (acc_start && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // control and store address registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run_r <= CTRL_RST;
      rom_addr_r <= 8'h00;
    end else begin
      if (acc_done && pwrite && paddr == OFS_CTRL) begin
        run_r <= pwdata[RUN_BIT];
      end
      if (acc_done && pwrite && paddr == OFS_ROM_ADDR) begin
        rom_addr_r <= pwdata[7:0];
      end else if (rom_we) begin
        rom_addr_r <= rom_addr_r + 8'h01;
      end
    end
  end

  // control store contents
  always_ff @(posedge clk_sys) begin
    if (rom_we) begin
      rom_mem[rom_addr_r] <= pwdata;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign next_microaddress_pointer = ptr_r;
  assign previous_microaddress = prev_r;
  assign microword = uword_r;
  assign display_select = disp_r;
  assign init_pulse = init_r;
  assign restart_delay_start = delay_r;
  assign trap_pending = trap_r;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_start;
    !run_r |=> ptr_r == START_ADDR;
  endproperty
  a_start: assert property (p_start) else $error("halted pointer not at start word");

  property p_plain_next;
    (run_r && mod_r == MOD_NONE) |=> ptr_r == $past(uword_r[7:0]);
  endproperty
  a_plain_next: assert property (p_plain_next) else $error("next address not from word field");

  property p_delay_one;
    (run_r && code == BR_HALT && halt_sync_r && mod_r == MOD_NONE) ##1 run_r |-> ptr_r == $past(uword_r[7:0]) ##1
      ptr_r[0];
  endproperty
  a_delay_one: assert property (p_delay_one) else $error("branch landed on wrong word");

  property p_or_low;
    (run_r && mod_r == MOD_ONE) |=> ptr_r == ($past(uword_r[7:0]) | 8'h01);
  endproperty
  a_or_low: assert property (p_or_low) else $error("low address bit not set");

  property p_halt_enable;
    (run_r && code == BR_HALT && !halt_sync_r) |=> mod_r == MOD_NONE;
  endproperty
  a_halt_enable: assert property (p_halt_enable) else $error("enable switch changed address");

  property p_dispatch;
    (run_r && code == BR_DISPATCH) |=> (mod_r == dispatch_index($past(instr_reg)) && mod_r <= 8'h18);
  endproperty
  a_dispatch: assert property (p_dispatch) else $error("dispatch index wrong");

  property p_priority;
    (run_r && code == BR_SVCFETCH && service_request) |=> mod_r == MOD_SERVICE;
  endproperty
  a_priority: assert property (p_priority) else $error("service did not win");

  property p_init;
    (run_r && code == BR_CONSOLE_TWO) |=> (init_pulse && restart_delay_start) ##1
      (!init_pulse || $past(code) == BR_CONSOLE_TWO);
  endproperty
  a_init: assert property (p_init) else $error("init or delay not started");

  property p_trap_clear;
    (run_r && code == BR_TRAP_CLEAR && trap_r != 4'h0 && trap_request == 4'h0) |=>
      (mod_r == MOD_NONE && $countones(trap_r) == $countones($past(trap_r)) - 1);
  endproperty
  a_trap_clear: assert property (p_trap_clear) else $error("trap flag not cleared alone");

  property p_fault;
    (run_r && code == BR_MEM_FAULT) |=> mod_r == {7'h00, $past(memory_mgmt_fault)};
  endproperty
  a_fault: assert property (p_fault) else $error("fault path not selected");

  property p_wrsel;
    (run_r && code == BR_WRSEL) |=> mod_r == write_select($past(instr_reg));
  endproperty
  a_wrsel: assert property (p_wrsel) else $error("write kind wrong");

  property p_display;
    // store words are unwritten until loaded, so check once running
    run_r |-> display_select == uword_r[DISP_LSB +: 3];
  endproperty
  a_display: assert property (p_display) else $error("display source mismatch");

  c_halt_taken: cover property (run_r && code == BR_HALT && halt_sync_r ##2 ptr_r[0]);
  c_dispatch: cover property (run_r && code == BR_DISPATCH ##1 mod_r == 8'h18);
  c_trap_clear: cover property (run_r && code == BR_TRAP_CLEAR && trap_r != 4'h0);
  c_apb_err: cover property (pslverr);
endmodule

/* hdl/useq_pkg.sv */
// constants for the microprogram branch sequencer
package useq_pkg;
  // microword layout
  localparam int WORD_W = 32;
  localparam int NEXT_LSB = 0;
  localparam int BRANCH_LSB = 8;
  localparam int DISP_LSB = 13;
  localparam int TRAP_W = 4;
  // first start-sequence word, octal 032
  localparam logic [7:0] START_ADDR = 8'h1A;
  // branch field codes (octal in comments)
  localparam logic [4:0] BR_NONE = 5'h00;      // 00
  localparam logic [4:0] BR_CONSOLE_ONE = 5'h01; // 01
  localparam logic [4:0] BR_CONSOLE_TWO = 5'h02; // 02
  localparam logic [4:0] BR_TRAP_CLEAR = 5'h03; // 03
  localparam logic [4:0] BR_HALT = 5'h08; // 10
  localparam logic [4:0] BR_MEM_FAULT = 5'h09; // 11
  localparam logic [4:0] BR_SVCFETCH = 5'h0E;  // 16
  localparam logic [4:0] BR_WRSEL = 5'h13;     // 23
  localparam logic [4:0] BR_DISPATCH = 5'h1F;  // 37
  // last dispatch index, 25 destinations 0..24
  localparam logic [4:0] DISPATCH_LAST = 5'h18;
  // address modifiers
  localparam logic [7:0] MOD_NONE = 8'h00;
  localparam logic [7:0] MOD_ONE = 8'h01;
  localparam logic [7:0] MOD_SERVICE = 8'h02;
  localparam logic [7:0] MOD_OVERLAP = 8'h01;
  localparam logic [7:0] WR_NONE = 8'h00;
  localparam logic [7:0] WR_BYTE = 8'h01;
  localparam logic [7:0] WR_WORD = 8'h02;
  // register map
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_ROM_ADDR = 12'h004;
  localparam logic [11:0] OFS_ROM_DATA = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam int RUN_BIT = 0;
  localparam logic CTRL_RST = 1'b0;
endpackage
